/* src/todc_pkg.sv */
package todc_pkg;

    // Register byte offsets
    localparam logic [5:0] OFS_HOUR_MIN   = 6'h00; // hour_and_minute_register
    localparam logic [5:0] OFS_SECONDS    = 6'h04;
    localparam logic [5:0] OFS_HM_MATCH   = 6'h08; // hour_minute_match_value
    localparam logic [5:0] OFS_SEC_MATCH  = 6'h0c; // second_match_value
    localparam logic [5:0] OFS_CONTROL    = 6'h10;
    localparam logic [5:0] OFS_FLAGS      = 6'h14; // interrupt_flag_bits
    localparam logic [5:0] OFS_ENABLES    = 6'h18; // interrupt_enable_bits
    localparam logic [5:0] OFS_COUNTDOWN  = 6'h1c;
    localparam logic [5:0] OFS_DATE       = 6'h20; // date_counter_register
    localparam logic [5:0] OFS_DATE_MATCH = 6'h24; // date_match_value

    // Field positions
    localparam int HOURS_LSB = 8;
    localparam int CTL_EN_BIT  = 7;  // Block enable
    localparam int CTL_REF_BIT = 5;  // 1 selects the 32 kHz reference
    localparam int FLG_CDOWN = 0;    // Minute countdown reached -1
    localparam int FLG_MIN   = 1;
    localparam int FLG_MATCH = 2;    // Also match_interrupt_enable
    localparam int FLG_DAY   = 3;
    localparam int FLG_1HZ   = 4;
    localparam int FLG_HOUR  = 5;    // hour_rollover_flag
    localparam int FLG_TICK  = 8;    // periodic_tick_select 0..7 at 8..15

    // Reset values
    localparam logic [7:0]  CTL_RESET   = 8'h80; // Clock enabled at reset
    localparam logic [5:0]  CDOWN_RESET = 6'h3f; // Idle at -1
    localparam logic [15:0] FLG_RESET   = 16'h0000;
    localparam logic [15:0] ENA_RESET   = 16'h0000;

    // Counts
    localparam int DIV_32K768   = 32768; // Reference cycles per second
    localparam int DIV_32K      = 32000;
    localparam int TICK_TAPS    = 8;
    localparam int TICK_CNT_W   = 13;    // 4 Hz is reference / 8192
    localparam logic [5:0] SEC_LAST  = 6'h3b;  // 59
    localparam logic [5:0] MIN_LAST  = 6'h3b;  // 59
    localparam logic [4:0] HOUR_LAST = 5'h17;  // 23

    // Counter snapshot carried as one word
    typedef struct packed {
        logic [8:0] days;
        logic [4:0] hours;
        logic [5:0] mins;
        logic [5:0] secs;
    } todc_tod_t;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } todc_bus_t;

endpackage : todc_pkg

/* src/todc_top.sv */
// Functional notes
// - Divide 32.768 or 32 kHz reference to 1 Hz
// - Divider taps feed the periodic sampling timer
// - Six-bit seconds counter advanced per 1 Hz tick
// - Minutes and hours share one combined register
// - Nine-bit day counter in its own register
// - 24-hour clock over 512 days, then wraps
// - Counters readable and writable at any time
// - Each seconds increment sets the 1 Hz flag
// - Seconds 59 to 00 advances minutes, sets flag
// - Minute rollover sets hour flag, hour rollover day
// - Hours 23 to 00 advances the day counter
// - Three match registers; equal time raises match flag
// - Enabled match repeats every 512 days
// - Eight select bits, sampling only while enabled
// - Each selected rate sets its own flag
// - Rates double from 4 Hz to 512 Hz
// - Countdown decrements per minute, fires at -1, holds
//
// Our own choices: the register addresses and the Avalon-MM register port.
module todc_top #(
    parameter int P_DIV_32K768 = todc_pkg::DIV_32K768,
    parameter int P_DIV_32K    = todc_pkg::DIV_32K
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ref_clk,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq
);

    // Divisors must fit the 16-bit prescaler and leave room to count
    if (P_DIV_32K768 < 2 || P_DIV_32K768 > 65536 ||
        P_DIV_32K < 2 || P_DIV_32K > 65536) begin : g_bad_div
        $error("Prescaler divisor out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release and reference edge

    logic                rst_meta_n;
    logic                rst_n;
    logic                ref_q;
    logic                ref_tick;

    // Asserted at once, released after two core edges
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Reference is slow and taken as synchronous; rising edge is the tick
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= i_ref_clk;
        end
    end
    assign ref_tick = i_ref_clk & ~ref_q;

    ////////////////////////////////////////////////////////////////////////
    // Register state and bus decode

    todc_pkg::todc_tod_t tod_reg;
    todc_pkg::todc_tod_t match_reg;
    logic [7:0]          ctl_reg;
    logic [15:0]         flg_reg;
    logic [15:0]         flg_next;
    logic [15:0]         ena_reg;
    logic [5:0]          cdown_reg;
    todc_pkg::todc_bus_t bus_reg;
    logic [31:0]         cur_word;
    logic [31:0]         be_mask;
    logic [31:0]         wr_word;
    logic                wr_fire;
    logic                rd_fire;
    logic                clk_en;

    assign clk_en = ctl_reg[todc_pkg::CTL_EN_BIT];

    // Present value of the addressed register; unmapped reads as zero
    always_comb begin
        cur_word = 32'h0000_0000;
        case (i_avs_address)
            todc_pkg::OFS_HOUR_MIN:   cur_word = {19'h0, tod_reg.hours,
                                                  2'h0, tod_reg.mins};
            todc_pkg::OFS_SECONDS:    cur_word = {26'h0, tod_reg.secs};
            todc_pkg::OFS_HM_MATCH:   cur_word = {19'h0, match_reg.hours,
                                                  2'h0, match_reg.mins};
            todc_pkg::OFS_SEC_MATCH:  cur_word = {26'h0, match_reg.secs};
            todc_pkg::OFS_CONTROL:    cur_word = {24'h0, ctl_reg};
            todc_pkg::OFS_FLAGS:      cur_word = {16'h0, flg_reg};
            todc_pkg::OFS_ENABLES:    cur_word = {16'h0, ena_reg};
            todc_pkg::OFS_COUNTDOWN:  cur_word = {26'h0, cdown_reg};
            todc_pkg::OFS_DATE:       cur_word = {23'h0, tod_reg.days};
            todc_pkg::OFS_DATE_MATCH: cur_word = {23'h0, match_reg.days};
            default:                  cur_word = 32'h0000_0000;
        endcase
    end

    // Byte lanes not enabled keep their present contents
    always_comb begin
        be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        wr_word = (cur_word & ~be_mask) | (i_avs_writedata & be_mask);
    end

    // One wait cycle: data captured on entry, request accepted in RESP
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_reg        <= todc_pkg::BUS_IDLE;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            case (bus_reg)
                todc_pkg::BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_reg        <= todc_pkg::BUS_RESP;
                        o_avs_readdata <= i_avs_read ? cur_word : 32'h0;
                    end
                end
                todc_pkg::BUS_RESP: bus_reg <= todc_pkg::BUS_IDLE;
                default:            bus_reg <= todc_pkg::BUS_IDLE;
            endcase
        end
    end
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) &
                               (bus_reg != todc_pkg::BUS_RESP);
    assign wr_fire = (bus_reg == todc_pkg::BUS_RESP) & i_avs_write;
    assign rd_fire = (bus_reg == todc_pkg::BUS_RESP) & i_avs_read;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and sampling taps

    logic [15:0]                      pre_reg;
    logic [15:0]                      pre_last;
    logic [todc_pkg::TICK_CNT_W-1:0]  tap_reg;
    logic [todc_pkg::TICK_TAPS-1:0]   tap_hit;
    logic                             sec_tick;

    // Terminal count follows the selected crystal frequency
    assign pre_last = ctl_reg[todc_pkg::CTL_REF_BIT] ?
                      16'(P_DIV_32K - 1) : 16'(P_DIV_32K768 - 1);
    assign sec_tick = ref_tick & clk_en & (pre_reg == pre_last);

    // Divider to one hertz; frozen while the block is disabled
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 16'h0000;
        end else if (ref_tick && clk_en) begin
            pre_reg <= sec_tick ? 16'h0000 : pre_reg + 16'h0001;
        end
    end

    // Binary tap chain; kept apart so 32 kHz rates stay exact halvings
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_reg <= '0;
        end else if (ref_tick && clk_en) begin
            tap_reg <= tap_reg + 1'b1;
        end
    end

    // Tap k fires every 8192 >> k reference cycles
    for (genvar k = 0; k < todc_pkg::TICK_TAPS; k++) begin : g_tap
        assign tap_hit[k] = ref_tick & clk_en &
                            (&tap_reg[todc_pkg::TICK_CNT_W-1-k:0]) &
                            ena_reg[todc_pkg::FLG_TICK+k];
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-of-day counters

    logic [5:0] secs_reg;
    logic [5:0] mins_reg;
    logic [4:0] hours_reg;
    logic [8:0] days_reg;
    logic       sec_wrap;
    logic       min_wrap;
    logic       hour_wrap;
    logic       wr_hm;

    // Seconds and days have their own process, minutes and hours share one; the snapshot is only a wire view
    assign tod_reg   = {days_reg, hours_reg, mins_reg, secs_reg};
    assign sec_wrap  = sec_tick & (secs_reg == todc_pkg::SEC_LAST);
    assign min_wrap  = sec_wrap & (mins_reg == todc_pkg::MIN_LAST);
    assign hour_wrap = min_wrap & (hours_reg == todc_pkg::HOUR_LAST);
    assign wr_hm     = wr_fire & (i_avs_address == todc_pkg::OFS_HOUR_MIN);

    // Seconds; a bus write wins over a tick in the same cycle
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            secs_reg <= 6'h00;
        end else if (wr_fire && i_avs_address == todc_pkg::OFS_SECONDS) begin
            secs_reg <= wr_word[5:0];
        end else if (sec_tick) begin
            secs_reg <= sec_wrap ? 6'h00 : secs_reg + 6'h01;
        end
    end

    // Minutes and hours live in one register
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mins_reg  <= 6'h00;
            hours_reg <= 5'h00;
        end else if (wr_hm) begin
            mins_reg  <= wr_word[5:0];
            hours_reg <= wr_word[todc_pkg::HOURS_LSB +: 5];
        end else if (sec_wrap) begin
            mins_reg <= min_wrap ? 6'h00 : mins_reg + 6'h01;
            if (min_wrap) begin
                hours_reg <= hour_wrap ? 5'h00 :
                             hours_reg + 5'h01;
            end
        end
    end

    // Day count wraps from 511 to 0 by its own width
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            days_reg <= 9'h000;
        end else if (wr_fire && i_avs_address == todc_pkg::OFS_DATE) begin
            days_reg <= wr_word[8:0];
        end else if (hour_wrap) begin
            days_reg <= days_reg + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, enables, match values and countdown

    // Plain software-owned registers
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg   <= todc_pkg::CTL_RESET;
            ena_reg   <= todc_pkg::ENA_RESET;
            match_reg <= '0;
        end else if (wr_fire) begin
            case (i_avs_address)
                todc_pkg::OFS_CONTROL:    ctl_reg <= wr_word[7:0];
                todc_pkg::OFS_ENABLES:    ena_reg <= wr_word[15:0];
                todc_pkg::OFS_SEC_MATCH:  match_reg.secs <= wr_word[5:0];
                todc_pkg::OFS_DATE_MATCH: match_reg.days <= wr_word[8:0];
                todc_pkg::OFS_HM_MATCH: begin
                    match_reg.mins  <= wr_word[5:0];
                    match_reg.hours <= wr_word[todc_pkg::HOURS_LSB +: 5];
                end
                default: ;
            endcase
        end
    end

    logic cdown_fire;

    assign cdown_fire = sec_wrap & (cdown_reg == 6'h00);

    // Counts down per minute tick, then rests at -1 until rewritten
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cdown_reg <= todc_pkg::CDOWN_RESET;
        end else if (wr_fire && i_avs_address == todc_pkg::OFS_COUNTDOWN) begin
            cdown_reg <= wr_word[5:0];
        end else if (sec_wrap && cdown_reg != todc_pkg::CDOWN_RESET) begin
            cdown_reg <= cdown_reg - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match detection, flags and interrupt

    logic match_now;
    logic match_q;
    logic match_hit;

    // Fires on the first cycle of equality, so once per 512-day lap
    assign match_now = (tod_reg == match_reg);
    assign match_hit = match_now & ~match_q &
                       ena_reg[todc_pkg::FLG_MATCH];

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_now;
        end
    end

    // Read clears only bits that were returned; a new event always wins
    always_comb begin
        flg_next = flg_reg;
        if (rd_fire && i_avs_address == todc_pkg::OFS_FLAGS) begin
            flg_next = flg_reg & ~o_avs_readdata[15:0];
        end
        flg_next[todc_pkg::FLG_1HZ]   |= sec_tick;
        flg_next[todc_pkg::FLG_MIN]   |= sec_wrap;
        flg_next[todc_pkg::FLG_HOUR]  |= min_wrap;
        flg_next[todc_pkg::FLG_DAY]   |= hour_wrap;
        flg_next[todc_pkg::FLG_MATCH] |= match_hit;
        flg_next[todc_pkg::FLG_CDOWN] |= cdown_fire;
        flg_next[todc_pkg::FLG_TICK +: todc_pkg::TICK_TAPS] |= tap_hit;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flg_reg <= todc_pkg::FLG_RESET;
        end else begin
            flg_reg <= flg_next;
        end
    end

    // Level output, high while any enabled flag stands
    assign o_irq = |(flg_reg & ena_reg);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_sec_wrap: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        sec_wrap && !wr_fire |=> tod_reg.secs == 6'h00)
        else $error("Seconds did not wrap to zero");

    chk_min_flag: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        sec_wrap |=> flg_reg[todc_pkg::FLG_MIN])
        else $error("Minute flag not set on rollover");

    chk_hz_flag: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        sec_tick && !wr_fire |=> flg_reg[todc_pkg::FLG_1HZ] &&
            tod_reg.secs != $past(tod_reg.secs))
        else $error("Second flag not set");

    chk_day_step: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        hour_wrap && !wr_fire |=> tod_reg.hours == 5'h00 &&
            tod_reg.days == $past(tod_reg.days) + 9'h001)
        else $error("Day did not advance at midnight");

    chk_pre_term: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        sec_tick |=> pre_reg == 16'h0000 ##1 pre_reg <= pre_last)
        else $error("Prescaler did not restart");

    chk_cdown_hold: assert property (@(posedge i_core_clk)
        disable iff (!rst_n)
        cdown_reg == 6'h3f && !wr_fire |=> cdown_reg == 6'h3f)
        else $error("Countdown left its rest value");

    chk_tap_gate: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        !clk_en && !wr_fire && !rd_fire
            |=> flg_reg[15:8] == $past(flg_reg[15:8]))
        else $error("Sampling flag rose while disabled");

    chk_match_irq: assert property (@(posedge i_core_clk)
        disable iff (!rst_n)
        match_hit |=> flg_reg[todc_pkg::FLG_MATCH] && o_irq)
        else $error("Match did not raise interrupt");

    chk_bus_resp: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest)
        else $error("Bus answer not after one wait cycle");

    chk_flag_sticky: assert property (@(posedge i_core_clk)
        disable iff (!rst_n)
        flg_reg[todc_pkg::FLG_DAY] && !rd_fire
            |=> flg_reg[todc_pkg::FLG_DAY])
        else $error("Day flag lost without a read");

endmodule : todc_top

/* tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV_A = 16; // Shortened second, 32.768 kHz reference
    localparam int DIV_B = 10; // Shortened second, 32 kHz reference
    localparam logic [5:0] HM   = todc_pkg::OFS_HOUR_MIN;
    localparam logic [5:0] SEC  = todc_pkg::OFS_SECONDS;
    localparam logic [5:0] HMM  = todc_pkg::OFS_HM_MATCH;
    localparam logic [5:0] SECM = todc_pkg::OFS_SEC_MATCH;
    localparam logic [5:0] CTL  = todc_pkg::OFS_CONTROL;
    localparam logic [5:0] FLG  = todc_pkg::OFS_FLAGS;
    localparam logic [5:0] ENA  = todc_pkg::OFS_ENABLES;
    localparam logic [5:0] CDN  = todc_pkg::OFS_COUNTDOWN;
    localparam logic [5:0] DAT  = todc_pkg::OFS_DATE;
    localparam logic [5:0] DATM = todc_pkg::OFS_DATE_MATCH;

    logic        clk;
    logic        rst_n;
    logic        ref_clk = 1'b0;
    logic [1:0]  ref_div = 2'h0;
    logic [5:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    logic [31:0] q;
    logic [31:0] qm;
    int          cyc = 0;
    int          t0;
    int          bad_count;
    int          samples_checked;
    // Start date, hm, seconds; then flags, date, hm, seconds after a tick
    logic [31:0] tv [5][7] = '{
        '{32'h1ff, 32'h173b, 32'h3b, 32'h3a, 32'h0, 32'h0, 32'h0},
        '{32'h006, 32'h173b, 32'h3b, 32'h3a, 32'h7, 32'h0, 32'h0},
        '{32'h006, 32'h0a3b, 32'h3b, 32'h32, 32'h6, 32'h0b00, 32'h0},
        '{32'h006, 32'h0a05, 32'h3b, 32'h12, 32'h6, 32'h0a06, 32'h0},
        '{32'h006, 32'h0a05, 32'h20, 32'h10, 32'h6, 32'h0a05, 32'h21}
    };

    todc_top #(
        .P_DIV_32K768 (DIV_A),
        .P_DIV_32K    (DIV_B)
    ) i_dut (
        .i_core_clk        (clk),
        .i_rst_n           (rst_n),
        .i_ref_clk         (ref_clk),
        .i_avs_address     (addr),
        .i_avs_read        (rd_en),
        .i_avs_write       (wr_en),
        .i_avs_writedata   (wdata),
        .i_avs_byteenable  (be),
        .o_avs_readdata    (rdata),
        .o_avs_waitrequest (waitreq),
        .o_irq             (irq)
    );

    ////////////////////////////////////////////////////////////////////
    // Core clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reference tick every four core cycles, so periods are exact
    always @(posedge clk) begin
        ref_div <= ref_div + 2'h1;
        ref_clk <= ref_div[1];
        cyc     <= cyc + 1;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Compared %0d values, %0d bad", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Cycle counts are seen through polling reads, hence the slack
    task automatic near(input string nm, input int e, input int g);
        samples_checked++;
        if (g < e - 3 || g > e + 3) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : near

    // One bus transfer held until waitrequest is sampled low
    task automatic xfer(input logic is_wr, input logic [5:0] a,
                        input logic [31:0] v, input logic [3:0] b);
        int n;
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        be    <= b;
        wr_en <= is_wr;
        rd_en <= ~is_wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (waitreq !== 1'b0) begin
            bad_count++;
            $display("BAD waitrequest expected 0 seen %b", waitreq);
            final_report();
        end
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        xfer(1'b1, a, v, 4'hf);
    endtask : wr

    task automatic rd(input logic [5:0] a);
        xfer(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task automatic rdchk(input string nm, input logic [5:0] a,
                         input logic [31:0] e);
        rd(a);
        check(nm, e, q);
    endtask : rdchk

    // Reads flags until a bit of m shows; the read clears what it saw
    task automatic poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            rd(FLG);
            n++;
        end while ((q & m) === 32'h0 && n < 2000);
        if ((q & m) === 32'h0) begin
            bad_count++;
            $display("BAD poll expected %h seen %h", m, q);
            final_report();
        end
    endtask : poll

    // Loads the counters while stopped, then runs to the next second
    task automatic roll(input logic [31:0] dt, hm, s);
        wr(CTL, 32'h0);
        wr(DAT, dt);
        wr(HM, hm);
        wr(SEC, s);
        rd(FLG);
        wr(CTL, 32'h80);
        poll(32'h10);
    endtask : roll

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 6'h00;
        wdata = 32'h0;
        be = 4'hf;
        bad_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk("control", CTL, 32'h80);
        // 32 kHz first, while the prescaler is still below its end count
        for (int i = 0; i < 2; i++) begin
            wr(CTL, (i == 0) ? 32'ha0 : 32'h80);
            poll(32'h10);
            t0 = cyc;
            poll(32'h10);
            near("second", (i == 0) ? 4 * DIV_B : 4 * DIV_A, cyc - t0);
        end
        rdchk("countdown", CDN, 32'h3f);
        rdchk("enables", ENA, 32'h0);
        wr(6'h28, 32'hffff);
        rdchk("unmapped", 6'h28, 32'h0);
        wr(CTL, 32'h0);
        rd(FLG);
        wr(FLG, 32'hffff);
        rdchk("flags_wr", FLG, 32'h0);
        $display("Test reset_and_rate done");
        for (int i = 0; i < 5; i++) begin
            roll(tv[i][0], tv[i][1], tv[i][2]);
            check("roll_flags", tv[i][3], q);
            rdchk("roll_date", DAT, tv[i][4]);
            rdchk("roll_hm", HM, tv[i][5]);
            rdchk("roll_sec", SEC, tv[i][6]);
        end
        $display("Test rollover done");
        wr(CDN, 32'h1);
        for (int i = 0; i < 3; i++) begin
            roll(32'h6, 32'h0a05, 32'h3b);
            check("cd_flags", (i == 1) ? 32'h13 : 32'h12, q);
            rdchk("cd_value", CDN, (i == 0) ? 32'h0 : 32'h3f);
        end
        $display("Test countdown done");
        wr(DATM, 32'h6);
        wr(HMM, 32'h0a06);
        wr(SECM, 32'h0);
        // Enabled, disabled by software, enabled again
        for (int i = 0; i < 3; i++) begin
            wr(ENA, (i == 1) ? 32'h0 : 32'h4);
            roll(32'h6, 32'h0a05, 32'h3b);
            qm = q;
            rd(FLG); // Match flag lands one edge after the tick
            qm = qm | q;
            check("match", (i == 1) ? 32'h12 : 32'h16, qm);
        end
        $display("Test match done");
        wr(ENA, 32'h10);
        rd(FLG);
        t0 = 0;
        while (irq !== 1'b1 && t0 < 200) begin
            @(posedge clk);
            t0++;
        end
        check("irq_raise", 32'h1, {31'h0, irq});
        rd(FLG);
        check("flag_1hz", 32'h10, q & 32'h10);
        @(posedge clk);
        check("irq_clear", 32'h0, {31'h0, irq});
        wr(ENA, 32'h0);
        rd(FLG);
        repeat (130) @(posedge clk);
        check("irq_masked", 32'h0, {31'h0, irq});
        rd(FLG);
        check("flag_sticky", 32'h10, q & 32'h10);
        $display("Test interrupt done");
        for (int k = 5; k < 8; k++) begin
            wr(ENA, 32'h100 << k);
            poll(32'h100 << k);
            t0 = cyc;
            poll(32'h100 << k);
            near("tap", 4 * (8192 >> k), cyc - t0);
        end
        wr(ENA, 32'hc000);
        rd(FLG);
        repeat (520) @(posedge clk);
        rd(FLG);
        check("taps_both", 32'hc000, q & 32'hff00);
        wr(CTL, 32'h0);
        rd(FLG);
        repeat (600) @(posedge clk);
        rd(FLG);
        check("taps_off", 32'h0, q & 32'hff10);
        $display("Test sampling done");
        // Only the minute lane is enabled, so hours must survive
        wr(HM, 32'h0a06);
        xfer(1'b1, HM, 32'h1f05, 4'h1);
        rdchk("hm_lane", HM, 32'h0a05);
        $display("Test byte_lane done");
        final_report();
    end

endmodule : testbench
